// *** design/ptprt_rate_trig.sv ***
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Trigger n shows an armed flag at bit 2n while enabled and not done.
// - Each notified trigger n shows a late error at bit 2n+1 if armed for a past time.
// - The late error is set only when that trigger's notification is enabled.
// - The late error clears when the trigger is disabled or rearmed only.
// - The rate value is 26 bits in 2^-32 ns, a 10-bit and a 16-bit part.
// - Each reference cycle the clock advances by period plus or minus rate.
// - Direction bit 15 of the upper register: 0 adds rate, 1 subtracts it.
// - Bit 14 makes the rate temporary, applied only for the set duration.
// - Upper writes are staged and the full rate loads on the lower write.
// - Upper register bits 9:0 hold the top ten rate bits, read-write, zero.
// - Lower register bits 15:0 hold the low sixteen rate bits, read-write.
// - Upper register bits 13:10 ignore writes and read as zero.
module ptprt_rate_trig
  import ptprt_pkg::*;
(
  input wire logic core_clk, // Reference clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] reg_addr, // Register address on the page.
  input wire logic reg_wr_en, // Write strobe, one cycle.
  input wire logic [DATA_W-1:0] reg_wdata, // Write data.
  output logic [DATA_W-1:0] reg_rdata_ff, // Read data, one cycle late.
  input wire logic [DUR_W-1:0] tmp_duration, // Temporary rate length, cycles.
  input wire ptprt_load_s clk_load, // Absolute clock load.
  input wire ptprt_trig_s trig_ctl, // Trigger arm, disable and done events.
  output logic [NUM_TRIG-1:0] trig_armed_ff, // Armed flags.
  output logic [NUM_TRIG-1:0] trig_err_ff, // Late error flags.
  output logic tmp_active_ff, // Temporary rate is in force.
  output ptprt_time_s clk_time // Clock time, whole nanoseconds.
);

  // ---------------------------------------------------------------------
  // Rate register state
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] high_stage_ff;
  logic [DATA_W-1:0] low_ff;
  ptprt_rate_s norm_rate_ff;
  ptprt_rate_s tmp_rate_ff;
  logic [DUR_W-1:0] tmp_cnt_ff;
  logic [DATA_W-1:0] nxt_high_stage;
  logic [DATA_W-1:0] nxt_low;
  ptprt_rate_s nxt_norm_rate;
  ptprt_rate_s nxt_tmp_rate;
  logic [DUR_W-1:0] nxt_tmp_cnt;
  logic nxt_tmp_active;
  logic wr_high;
  logic wr_low;
  ptprt_rate_s loaded_rate;

  // Decodes the two rate register writes.
  always_comb begin
    wr_high = reg_wr_en && (reg_addr == ADDR_RATE_HIGH);
    wr_low = reg_wr_en && (reg_addr == ADDR_RATE_LOW);
  end

  // Stages the upper half and commits the whole rate on the lower write.
  always_comb begin
    nxt_high_stage = high_stage_ff;
    nxt_low = low_ff;
    nxt_norm_rate = norm_rate_ff;
    nxt_tmp_rate = tmp_rate_ff;
    nxt_tmp_cnt = tmp_cnt_ff;
    loaded_rate.dir = high_stage_ff[HIGH_DIR_BIT];
    loaded_rate.value = {high_stage_ff[UPPER_W-1:0], reg_wdata};
    if (tmp_cnt_ff != '0) begin
      nxt_tmp_cnt = tmp_cnt_ff - 32'h00000001;
    end
    if (wr_high) begin
      nxt_high_stage = reg_wdata & HIGH_KEEP_MASK;
    end
    if (wr_low) begin
      nxt_low = reg_wdata;
      if (high_stage_ff[HIGH_TMP_BIT]) begin
        nxt_tmp_rate = loaded_rate;
        nxt_tmp_cnt = tmp_duration;
      end else begin
        nxt_norm_rate = loaded_rate;
        nxt_tmp_cnt = '0;
      end
    end
    nxt_tmp_active = (nxt_tmp_cnt != '0);
  end

  // Registers the rate state.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      high_stage_ff <= RATE_HIGH_RESET;
      low_ff <= RATE_LOW_RESET;
      norm_rate_ff <= '0;
      tmp_rate_ff <= '0;
      tmp_cnt_ff <= '0;
      tmp_active_ff <= 1'b0;
    end else begin
      high_stage_ff <= nxt_high_stage;
      low_ff <= nxt_low;
      norm_rate_ff <= nxt_norm_rate;
      tmp_rate_ff <= nxt_tmp_rate;
      tmp_cnt_ff <= nxt_tmp_cnt;
      tmp_active_ff <= nxt_tmp_active;
    end
  end

  // ---------------------------------------------------------------------
  // Per-cycle clock step
  // ---------------------------------------------------------------------
  ptprt_rate_s act_rate;
  logic [ACC_W-1:0] base_step;
  logic [ACC_W-1:0] rate_ext;
  logic [ACC_W-1:0] step_inc;

  // Picks the rate in force and forms period plus or minus rate.
  always_comb begin
    act_rate = (tmp_cnt_ff != '0) ? tmp_rate_ff : norm_rate_ff;
    base_step = {REF_PERIOD_NS[NS_W-1:0], {FRAC_W{1'b0}}};
    rate_ext = {{(ACC_W-RATE_W){1'b0}}, act_rate.value};
    if (act_rate.dir) begin
      step_inc = base_step - rate_ext;
    end else begin
      step_inc = base_step + rate_ext;
    end
  end

  // Accumulates the clock time with full fractional precision.
  ptprt_time_acc u_time_acc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .step_inc(step_inc),
    .load_req(clk_load),
    .time_ff(clk_time)
  );

  // ---------------------------------------------------------------------
  // Trigger status flags
  // ---------------------------------------------------------------------
  logic target_late;
  logic [NUM_TRIG-1:0] nxt_armed;
  logic [NUM_TRIG-1:0] nxt_err;

  // Compares the programmed fire time against the present clock time.
  always_comb begin
    target_late = ({trig_ctl.target.sec, trig_ctl.target.ns} <
                   {clk_time.sec, clk_time.ns});
  end

  // Computes each trigger's armed and late error flags.
  genvar n;
  generate
    for (n = 0; n < NUM_TRIG; n = n + 1) begin : g_trig
      always_comb begin
        nxt_armed[n] = trig_armed_ff[n];
        nxt_err[n] = trig_err_ff[n];
        if (trig_ctl.off[n] || trig_ctl.done[n]) begin
          nxt_armed[n] = 1'b0;
        end
        if (trig_ctl.off[n] || trig_ctl.arm[n]) begin
          nxt_err[n] = 1'b0;
        end
        if (trig_ctl.arm[n] && !trig_ctl.off[n]) begin
          nxt_armed[n] = 1'b1;
          // The fresh late check wins over the clear of the rearm.
          nxt_err[n] = target_late && trig_ctl.notify[n];
        end
      end
    end
  endgenerate

  // Registers the trigger flags.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_armed_ff <= '0;
      trig_err_ff <= '0;
    end else begin
      trig_armed_ff <= nxt_armed;
      trig_err_ff <= nxt_err;
    end
  end

  // ---------------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] state_word;

  // Interleaves the flags: armed at even bits, error at odd bits.
  generate
    for (n = 0; n < NUM_TRIG; n = n + 1) begin : g_word
      assign state_word[2*n] = trig_armed_ff[n];
      assign state_word[2*n+1] = trig_err_ff[n];
    end
  endgenerate

  // Selects the addressed register; unmapped offsets read as zero.
  always_comb begin
    case (reg_addr)
      ADDR_TRIG_STATE: nxt_rdata = state_word;
      ADDR_RATE_LOW: nxt_rdata = low_ff;
      ADDR_RATE_HIGH: nxt_rdata = high_stage_ff & HIGH_KEEP_MASK;
      default: nxt_rdata = '0;
    endcase
  end

  // Registers the read data; writes to the status word are ignored.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule : ptprt_rate_trig

`default_nettype wire

// *** common/ptprt_pkg.sv ***
package ptprt_pkg;

  // ---------------------------------------------------------------------
  // Clocking and time constants
  // ---------------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 50;
  localparam int NS_PER_US = 1000;
  localparam int REF_PERIOD_NS = NS_PER_US / CLK_FREQ_MHZ;

  // ---------------------------------------------------------------------
  // Register offsets on the management register page
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_TRIG_STATE = 5'h17;
  localparam logic [ADDR_W-1:0] ADDR_RATE_LOW = 5'h18;
  localparam logic [ADDR_W-1:0] ADDR_RATE_HIGH = 5'h19;

  // ---------------------------------------------------------------------
  // Field layout of the rate registers
  // ---------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int HIGH_DIR_BIT = 15;
  localparam int HIGH_TMP_BIT = 14;
  localparam int UPPER_W = 10;
  localparam int LOWER_W = 16;
  localparam int RATE_W = UPPER_W + LOWER_W;
  localparam logic [DATA_W-1:0] RATE_LOW_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RATE_HIGH_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] HIGH_KEEP_MASK = 16'hc3ff;

  // ---------------------------------------------------------------------
  // Time clock layout
  // ---------------------------------------------------------------------
  localparam int NUM_TRIG = 8;
  localparam int FRAC_W = 32;
  localparam int NS_W = 30;
  localparam int SEC_W = 32;
  localparam int ACC_W = NS_W + FRAC_W;
  localparam int DUR_W = 32;
  localparam logic [NS_W-1:0] NS_PER_SEC = 30'h3b9aca00;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [SEC_W-1:0] sec;
    logic [NS_W-1:0] ns;
  } ptprt_time_s;

  typedef struct packed {
    logic dir;
    logic [RATE_W-1:0] value;
  } ptprt_rate_s;

  typedef struct packed {
    logic load;
    ptprt_time_s value;
  } ptprt_load_s;

  typedef struct packed {
    logic [NUM_TRIG-1:0] arm;
    logic [NUM_TRIG-1:0] off;
    logic [NUM_TRIG-1:0] done;
    logic [NUM_TRIG-1:0] notify;
    ptprt_time_s target;
  } ptprt_trig_s;

endpackage : ptprt_pkg

// *** design/ptprt_time_acc.sv ***
`timescale 1ns/10ps
`default_nettype none

// Time clock accumulator: seconds, nanoseconds and 32 fractional bits.
module ptprt_time_acc
  import ptprt_pkg::*;
(
  input wire logic core_clk, // Reference clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [ACC_W-1:0] step_inc, // Per-cycle step in 2^-32 ns.
  input wire ptprt_load_s load_req, // Absolute time load.
  output ptprt_time_s time_ff // Integer part of the clock time.
);

  logic [FRAC_W-1:0] frac_ff;
  logic [FRAC_W-1:0] nxt_frac;
  ptprt_time_s nxt_time;
  logic [ACC_W-1:0] sum;

  // Adds the step and wraps nanoseconds into the seconds count.
  always_comb begin
    sum = {time_ff.ns, frac_ff} + step_inc;
    nxt_frac = sum[FRAC_W-1:0];
    nxt_time.sec = time_ff.sec;
    nxt_time.ns = sum[ACC_W-1:FRAC_W];
    if (sum[ACC_W-1:FRAC_W] >= NS_PER_SEC) begin
      nxt_time.ns = sum[ACC_W-1:FRAC_W] - NS_PER_SEC;
      nxt_time.sec = time_ff.sec + 32'h00000001;
    end
    if (load_req.load) begin
      nxt_time = load_req.value;
      nxt_frac = '0;
    end
  end

  // Registers the accumulator.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      time_ff <= '0;
      frac_ff <= '0;
    end else begin
      time_ff <= nxt_time;
      frac_ff <= nxt_frac;
    end
  end

endmodule : ptprt_time_acc

`default_nettype wire

// *** dv/ptprt_rate_trig_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// ------------------------
// Port checker
// ------------------------
module ptprt_rate_trig_chk
  import ptprt_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Reset.
  input wire logic [ADDR_W-1:0] reg_addr, // Address.
  input wire logic [DATA_W-1:0] reg_rdata_ff, // Read data.
  input wire ptprt_load_s clk_load, // Clock load.
  input wire ptprt_trig_s trig_ctl, // Trigger events.
  input wire logic [NUM_TRIG-1:0] trig_armed_ff, // Armed.
  input wire logic [NUM_TRIG-1:0] trig_err_ff, // Errors.
  input wire logic tmp_active_ff, // Temporary rate.
  input wire ptprt_time_s clk_time // Clock time.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Arms that are not overruled by a disable in the same cycle.
  wire logic [NUM_TRIG-1:0] arm_go = trig_ctl.arm & ~trig_ctl.off;

  arm_sets_a: assert property (|arm_go |=>
    (trig_armed_ff & $past(arm_go)) == $past(arm_go))
    else $error("armed flag missing after arm");
  done_clears_a: assert property (|trig_ctl.done |=>
    !(|(trig_armed_ff & $past(trig_ctl.done & ~trig_ctl.arm))))
    else $error("armed flag kept after done");
  off_clears_a: assert property (|trig_ctl.off |=>
    !(|((trig_armed_ff | trig_err_ff) & $past(trig_ctl.off))))
    else $error("flags kept after disable");
  err_cause_a: assert property (
    !(|(trig_err_ff & ~$past(trig_err_ff)
    & ~$past(arm_go & trig_ctl.notify))))
    else $error("error flag without notified arm");
  err_sticky_a: assert property (!(|(~trig_err_ff & $past(trig_err_ff)
    & ~$past(trig_ctl.off | trig_ctl.arm))))
    else $error("error flag dropped on its own");
  rsvd_zero_a: assert property ($past(reg_addr) == ADDR_RATE_HIGH |->
    reg_rdata_ff[13:10] == 4'h0)
    else $error("reserved rate bits not zero");
  // The first edge after reset still shows the reset time, so skip it.
  step_size_a: assert property ($past(reset_n) &&
    !$past(clk_load.load) &&
    $past(clk_time.ns) < NS_PER_SEC - 30'h40 |->
    clk_time.ns - $past(clk_time.ns) inside {[19:21]})
    else $error("clock step out of range");
  load_take_a: assert property ($past(clk_load.load) |->
    clk_time == $past(clk_load.value))
    else $error("clock load not taken");

  cover property (|trig_err_ff);
  cover property ($fell(tmp_active_ff));
  cover property (clk_load.load);
endmodule : ptprt_rate_trig_chk

bind ptprt_rate_trig ptprt_rate_trig_chk chk_i (.core_clk(core_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_rdata_ff(reg_rdata_ff),
  .clk_load(clk_load), .trig_ctl(trig_ctl), .trig_armed_ff(trig_armed_ff),
  .trig_err_ff(trig_err_ff), .tmp_active_ff(tmp_active_ff),
  .clk_time(clk_time));

`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import ptprt_pkg::*;
  logic core_clk, reset_n, reg_wr_en, late;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_ff, hi, lo;
  logic [DUR_W-1:0] tmp_duration;
  ptprt_load_s clk_load;
  ptprt_trig_s trig_ctl;
  logic [NUM_TRIG-1:0] trig_armed_ff, trig_err_ff, ea, ee;
  logic tmp_active_ff;
  ptprt_time_s clk_time;
  int error_cnt, checks_done, cyc;

  ptprt_rate_trig dut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff), .tmp_duration(tmp_duration),
    .clk_load(clk_load), .trig_ctl(trig_ctl),
    .trig_armed_ff(trig_armed_ff), .trig_err_ff(trig_err_ff),
    .tmp_active_ff(tmp_active_ff), .clk_time(clk_time));

  // ------------------------
  // Helpers
  // ------------------------
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    chk("rdata", 64'(e), 64'(reg_rdata_ff));
  endtask : rd

  // Loads a time, runs 200 cycles and checks the whole nanoseconds.
  task automatic tchk(string nm, logic [RATE_W-1:0] r, logic d);
    longint e;
    logic [NS_W-1:0] v;
    v = NS_W'($urandom_range(100000, 1000));
    @(posedge core_clk);
    clk_load.value.ns <= v;
    clk_load.load <= 1'b1;
    @(posedge core_clk);
    clk_load.load <= 1'b0;
    repeat (200) @(posedge core_clk);
    @(negedge core_clk);
    e = (longint'(REF_PERIOD_NS) <<< 32) + (d ? -longint'(r) : longint'(r));
    e = (longint'(v) <<< 32) + 200 * e;
    chk(nm, 64'(e >>> 32), 64'(clk_time.ns));
  endtask : tchk

  // Pulses arm (0), done (1) or disable (2) for one trigger.
  task automatic pulse(int k, int n, logic [SEC_W-1:0] s);
    @(posedge core_clk);
    trig_ctl.target.sec <= s;
    if (k == 0) trig_ctl.arm[n] <= 1'b1;
    else if (k == 1) trig_ctl.done[n] <= 1'b1;
    else trig_ctl.off[n] <= 1'b1;
    @(posedge core_clk);
    trig_ctl.arm <= '0;
    trig_ctl.done <= '0;
    trig_ctl.off <= '0;
    @(negedge core_clk);
  endtask : pulse

  // Compares the flag outputs and the interleaved status word.
  task automatic stat();
    logic [DATA_W-1:0] w;
    // Looks at the flags away from any edge that could launch them.
    @(negedge core_clk);
    for (int i = 0; i < NUM_TRIG; i++) w[2*i+:2] = {ee[i], ea[i]};
    chk("armed", 64'(ea), 64'(trig_armed_ff));
    chk("err", 64'(ee), 64'(trig_err_ff));
    rd(ADDR_TRIG_STATE, w);
  endtask : stat

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Clock and hang guard.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ------------------------
  // Main sequence
  // ------------------------
  initial begin
    void'($urandom(32'h98cfc3c2));
    reset_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    tmp_duration = '0;
    clk_load = '0;
    trig_ctl = '0;
    ea = '0;
    ee = '0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ADDR_RATE_LOW, RATE_LOW_RESET);
    rd(ADDR_RATE_HIGH, RATE_HIGH_RESET);
    wr(ADDR_RATE_HIGH, 16'hffff);
    rd(ADDR_RATE_HIGH, HIGH_KEEP_MASK);
    tchk("staged", '0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      hi = {i[0], 5'h00, 10'($urandom)};
      lo = 16'($urandom);
      wr(ADDR_RATE_HIGH, hi);
      wr(ADDR_RATE_LOW, lo);
      rd(ADDR_RATE_HIGH, hi);
      rd(ADDR_RATE_LOW, lo);
      tchk("rate", {hi[9:0], lo}, hi[15]);
    end
    $display("test rates done");
    wr(ADDR_RATE_HIGH, 16'h0000);
    wr(ADDR_RATE_LOW, 16'h0000);
    tmp_duration <= 32'h0000000a;
    wr(ADDR_RATE_HIGH, 16'h43ff);
    wr(ADDR_RATE_LOW, 16'hffff);
    repeat (2) @(negedge core_clk);
    chk("tmp_on", 64'h1, 64'(tmp_active_ff));
    repeat (14) @(negedge core_clk);
    chk("tmp_off", 64'h0, 64'(tmp_active_ff));
    // A slower temporary rate of 300 cycles must show in the clock time.
    @(posedge core_clk);
    tmp_duration <= 32'h0000012c;
    wr(ADDR_RATE_HIGH, 16'hc3ff);
    wr(ADDR_RATE_LOW, 16'hffff);
    tchk("tmp_rate", 26'h3ffffff, 1'b1);
    chk("tmp_hold", 64'h1, 64'(tmp_active_ff));
    repeat (120) @(negedge core_clk);
    chk("tmp_end", 64'h0, 64'(tmp_active_ff));
    tchk("after_tmp", '0, 1'b0);
    $display("test temporary done");
    @(posedge core_clk);
    // Trigger 0 is always notified and trigger 1 never is.
    trig_ctl.notify <= (8'($urandom) | 8'h01) & 8'hfd;
    for (int n = 0; n < NUM_TRIG; n++) begin
      late = (n != 7);
      pulse(0, n, late ? '0 : '1);
      ea[n] = 1'b1;
      ee[n] = late & trig_ctl.notify[n];
      stat();
      pulse(1, n, '1);
      ea[n] = 1'b0;
      stat();
      wr(ADDR_TRIG_STATE, 16'hffff);
      stat();
      pulse(n % 2 ? 2 : 0, n, '1);
      ea[n] = !(n % 2);
      ee[n] = 1'b0;
      stat();
    end
    // Arm and disable together on a late, notified trigger: disable wins.
    @(posedge core_clk);
    trig_ctl.target.sec <= '0;
    trig_ctl.arm[0] <= 1'b1;
    trig_ctl.off[0] <= 1'b1;
    @(posedge core_clk);
    trig_ctl.arm <= '0;
    trig_ctl.off <= '0;
    ea[0] = 1'b0;
    ee[0] = 1'b0;
    stat();
    $display("test triggers done");
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
